// >>> two_wire_pkg.sv
`default_nettype none
package two_wire_pkg;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int NV_WRITE_MS = 10;
  // Longest write time, rounded down to whole core cycles
  localparam int NV_WRITE_CYCLES_DEF = NV_WRITE_MS * 1000 * CLK_MHZ;
  // ---------------------------------------------
  // Control byte layout
  // ---------------------------------------------
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [3:0] DEVICE_TYPE_DEF = 4'h6; // Arbitrary value
  // ---------------------------------------------
  // Commands and register layout
  // ---------------------------------------------
  localparam logic [7:0] CMD_DIV = 8'h01;
  localparam logic [7:0] CMD_PRESC = 8'h02;
  localparam logic [7:0] CMD_SELECT = 8'h0D;
  localparam logic [7:0] CMD_COMMIT = 8'h3F;
  localparam int WORD_W = 10;
  localparam int MODE_BIT = 3;
  localparam logic [WORD_W-1:0] DIV_RESET = 10'h000;
  localparam logic [WORD_W-1:0] PRESC_RESET = 10'h000;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic MODE_RESET = 1'h0;
  // Commit mask bit positions
  localparam int MASK_WORDS = 0;
  localparam int MASK_SEL = 1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  // Bus-side phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_RX = 3'b001,
    PH_ACK = 3'b010,
    PH_TX = 3'b011,
    PH_TXACK = 3'b100,
    PH_IGN = 3'b101
  } phase_t;
endpackage : two_wire_pkg
`default_nettype wire

// >>> nv_link_if.sv
`default_nettype none
// Commit request from the bus side to the store side; words held stable until ack matches req
interface nv_link_if;
  logic req;
  logic [1:0] mask;
  logic [9:0] div;
  logic [9:0] presc;
  logic [2:0] sel;
  logic mode;
  logic ack;
  modport link (output req, output mask, output div, output presc, output sel, output mode, input ack);
  modport core (input req, input mask, input div, input presc, input sel, input mode, output ack);
endinterface : nv_link_if
`default_nettype wire

// >>> nv_commit_core.sv
`default_nettype none
module nv_commit_core
  import two_wire_pkg::*;
#(
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rstn,
  nv_link_if.core lnk,
  output logic nv_busy,
  output logic nv_write_strobe,
  output logic [WORD_W-1:0] nv_divider_word,
  output logic [WORD_W-1:0] nv_prescaler_config_word,
  output logic [2:0] nv_select_bits,
  output logic nv_commit_mode_stored
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam logic [TW-1:0] LOAD = TW'(WRITE_CYCLES - 1);

  typedef struct packed {
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic ack;
    logic busy;
    logic strobe;
    logic [TW-1:0] timer;
    logic [WORD_W-1:0] div;
    logic [WORD_W-1:0] presc;
    logic [2:0] sel;
    logic mode;
  } core_state_t;

  core_state_t core;
  core_state_t next_core;

  // ---------------------------------------------
  // Store engine
  // ---------------------------------------------
  // Words need no synchroniser: the bus side freezes them until ack comes back
  always_comb
  begin
    next_core = core;
    next_core.req_meta = lnk.req;
    next_core.req_sync = core.req_meta;
    next_core.strobe = 1'b0;
    if (!core.busy && core.req_sync != core.req_seen)
    begin
      next_core.req_seen = core.req_sync;
      next_core.busy = 1'b1;
      next_core.strobe = 1'b1;
      next_core.timer = LOAD;
      if (lnk.mask[MASK_WORDS])
      begin
        next_core.div = lnk.div;
        next_core.presc = lnk.presc;
      end
      if (lnk.mask[MASK_SEL])
      begin
        next_core.sel = lnk.sel;
        next_core.mode = lnk.mode;
      end
    end
    else if (core.busy)
    begin
      if (core.timer == '0)
      begin
        next_core.busy = 1'b0;
        next_core.ack = core.req_seen;
      end
      else
        next_core.timer = core.timer - TW'(1);
    end
    if (!rstn)
    begin
      next_core = '0;
      next_core.div = DIV_RESET;
      next_core.presc = PRESC_RESET;
      next_core.sel = SEL_RESET;
      next_core.mode = MODE_RESET;
    end
  end

  always_ff @(posedge clk)
    core <= next_core;

  assign lnk.ack = core.ack;
  assign nv_busy = core.busy;
  assign nv_write_strobe = core.strobe;
  assign nv_divider_word = core.div;
  assign nv_prescaler_config_word = core.presc;
  assign nv_select_bits = core.sel;
  assign nv_commit_mode_stored = core.mode;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_nv_busy_load: assert property (
    $rose(core.busy) |-> core.timer == LOAD && core.strobe)
  else $error("write cycle started without full time");

  a_nv_busy_release: assert property (
    core.busy && core.timer == '0 |=> !core.busy && core.ack == core.req_seen)
  else $error("busy not released at end of write");

  a_nv_capture: assert property (
    (!core.busy && core.req_sync != core.req_seen && lnk.mask[MASK_WORDS])
    |=> core.div == $past(lnk.div) && core.presc == $past(lnk.presc))
  else $error("words not stored on commit");
endmodule : nv_commit_core
`default_nettype wire

// >>> two_wire_slave_nv_commit.sv
// Overview of operation
// - Mode clear: store words after every write
// - Mode set: store words only on commit
// - Commit command stores divider and prescaler words
// - Select register write always stored at once
// - Slave only; SDA driven open-drain
// - SDA fall, SCL high is START
// - SDA rise, SCL high is STOP
// - SDA changes only while SCL low
// - Eight-bit bytes, ninth bit acknowledges
// - Works at standard and fast rates
// - Acknowledge holds SDA low through high phase
// - Refuse all requests while store busy
// - Master nack ends read; release SDA
// - Write: acknowledge address and every byte
// - Repeated START restarts control byte reception
// - Control byte: type, select, direction
// - Select bits default zero, writable
// - Direction one reads, zero writes
// - Acknowledge control byte only on match
// - Transmit data clocked by master SCL
// - Command byte follows write control byte
// - Store write lasts up to ten milliseconds
`default_nettype none
module two_wire_slave_nv_commit
  import two_wire_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_DEF,
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [WORD_W-1:0] divider_word,
  output logic [WORD_W-1:0] prescaler_config_word,
  output logic nv_commit_mode,
  output logic select_bit_2,
  output logic select_bit_1,
  output logic select_bit_0,
  output logic nv_busy,
  output logic nv_write_strobe,
  output logic [WORD_W-1:0] nv_divider_word,
  output logic [WORD_W-1:0] nv_prescaler_config_word,
  output logic [2:0] nv_select_bits,
  output logic nv_commit_mode_stored
);
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic scl_meta;
    logic scl_sync;
    logic scl_d;
    logic scl_f;
    logic scl_p;
    logic sda_meta;
    logic sda_sync;
    logic sda_d;
    logic sda_f;
    logic sda_p;
    logic ack_meta;
    logic ack_sync;
    phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic go_tx;
    logic go_ign;
    logic half;
    logic master_ack;
    logic [7:0] cmd;
    logic [7:0] data_hi;
    logic [WORD_W-1:0] div;
    logic [WORD_W-1:0] presc;
    logic [2:0] sel;
    logic mode;
    logic dirty_words;
    logic dirty_sel;
    logic commit_cmd;
    logic req;
    logic [1:0] mask;
    logic sda_oe_n;
  } link_state_t;

  link_state_t link;
  link_state_t next_link;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic link_busy;
  logic ctrl_match;
  logic [1:0] commit_mask;
  // Carrier to the store side; declared here because the bus logic reads its ack
  nv_link_if lnk ();

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // Ten-bit words travel high eight bits first, then two bits left-aligned
  function automatic logic [7:0] word_byte(input logic [WORD_W-1:0] w, input logic half);
    word_byte = half ? {w[1:0], 6'h00} : w[9:2];
  endfunction : word_byte

  // Byte to send for the last command received
  function automatic logic [7:0] tx_byte(input link_state_t st);
    case (st.cmd)
      CMD_DIV: tx_byte = word_byte(st.div, st.half);
      CMD_PRESC: tx_byte = word_byte(st.presc, st.half);
      CMD_SELECT: tx_byte = {4'h0, st.mode, st.sel};
      default: tx_byte = 8'h00;
    endcase
  endfunction : tx_byte

  // Bus events seen on the filtered lines; both lines share the same delay
  assign scl_rise = link.scl_f && !link.scl_p;
  assign scl_fall = !link.scl_f && link.scl_p;
  assign start_evt = link.scl_f && link.scl_p && link.sda_p && !link.sda_f;
  assign stop_evt = link.scl_f && link.scl_p && !link.sda_p && link.sda_f;

  // A commit is in flight until the store side echoes the toggle
  assign link_busy = link.req != link.ack_sync;
  assign ctrl_match = link.shreg[TYPE_MSB:TYPE_LSB] == DEVICE_TYPE
    && link.shreg[SEL_MSB:SEL_LSB] == link.sel && !link_busy;

  // What the ending transfer must put in the store
  assign commit_mask[MASK_WORDS] = (link.dirty_words && !link.mode) || link.commit_cmd;
  assign commit_mask[MASK_SEL] = link.dirty_sel;

  // ---------------------------------------------
  // Bus-side state machine
  // ---------------------------------------------
  // Start and stop win over bit handling so a broken byte never reaches a register
  always_comb
  begin
    next_link = link;
    next_link.rst_meta = rstn;
    next_link.rst_sync = link.rst_meta;
    // Two-stage synchronisers, then a two-sample agreement filter
    next_link.scl_meta = scl_in;
    next_link.scl_sync = link.scl_meta;
    next_link.scl_d = link.scl_sync;
    if (link.scl_sync == link.scl_d)
      next_link.scl_f = link.scl_d;
    next_link.scl_p = link.scl_f;
    next_link.sda_meta = sda_in;
    next_link.sda_sync = link.sda_meta;
    next_link.sda_d = link.sda_sync;
    if (link.sda_sync == link.sda_d)
      next_link.sda_f = link.sda_d;
    next_link.sda_p = link.sda_f;
    next_link.ack_meta = lnk.ack;
    next_link.ack_sync = link.ack_meta;
    if (start_evt || stop_evt)
    begin
      if (|commit_mask)
      begin
        next_link.req = !link.req;
        next_link.mask = commit_mask;
      end
      next_link.dirty_words = 1'b0;
      next_link.dirty_sel = 1'b0;
      next_link.commit_cmd = 1'b0;
      next_link.sda_oe_n = 1'b1;
      next_link.bit_cnt = 4'h0;
      next_link.byte_idx = 2'h0;
      next_link.phase = start_evt ? PH_RX : PH_IDLE;
    end
    else
    begin
      case (link.phase)
        PH_RX:
        begin
          if (scl_rise)
          begin
            next_link.shreg = {link.shreg[6:0], link.sda_f};
            next_link.bit_cnt = link.bit_cnt + 4'h1;
          end
          else if (scl_fall && link.bit_cnt == BYTE_BITS)
          begin
            next_link.bit_cnt = 4'h0;
            next_link.phase = PH_ACK;
            next_link.go_tx = 1'b0;
            next_link.go_ign = 1'b0;
            next_link.sda_oe_n = 1'b0;
            if (link.byte_idx != 2'h2)
              next_link.byte_idx = link.byte_idx + 2'h1;
            case (link.byte_idx)
              2'h0:
              begin
                next_link.sda_oe_n = !ctrl_match;
                next_link.go_ign = !ctrl_match;
                next_link.go_tx = ctrl_match && link.shreg[RW_BIT];
                next_link.half = 1'b0;
              end
              2'h1:
              begin
                next_link.cmd = link.shreg;
                next_link.half = 1'b0;
                if (link.shreg == CMD_COMMIT)
                  next_link.commit_cmd = 1'b1;
              end
              default:
              begin
                next_link.half = !link.half;
                case (link.cmd)
                  CMD_DIV:
                  begin
                    if (!link.half)
                      next_link.data_hi = link.shreg;
                    else
                    begin
                      next_link.div = {link.data_hi, link.shreg[7:6]};
                      next_link.dirty_words = 1'b1;
                    end
                  end
                  CMD_PRESC:
                  begin
                    if (!link.half)
                      next_link.data_hi = link.shreg;
                    else
                    begin
                      next_link.presc = {link.data_hi, link.shreg[7:6]};
                      next_link.dirty_words = 1'b1;
                    end
                  end
                  CMD_SELECT:
                  begin
                    next_link.sel = link.shreg[2:0];
                    next_link.mode = link.shreg[MODE_BIT];
                    next_link.dirty_sel = 1'b1;
                  end
                  default:
                    next_link.half = link.half;
                endcase
              end
            endcase
          end
        end
        PH_ACK:
        begin
          // Held through the ninth high phase, dropped on its falling edge
          if (scl_fall)
          begin
            next_link.sda_oe_n = 1'b1;
            if (link.go_ign)
              next_link.phase = PH_IGN;
            else if (link.go_tx)
            begin
              next_link.shreg = tx_byte(link);
              next_link.sda_oe_n = next_link.shreg[7];
              next_link.half = !link.half;
              next_link.phase = PH_TX;
            end
            else
              next_link.phase = PH_RX;
          end
        end
        PH_TX:
        begin
          if (scl_fall)
          begin
            if (link.bit_cnt == TX_LAST)
            begin
              next_link.bit_cnt = 4'h0;
              next_link.sda_oe_n = 1'b1;
              next_link.phase = PH_TXACK;
            end
            else
            begin
              next_link.shreg = {link.shreg[6:0], 1'b0};
              next_link.sda_oe_n = link.shreg[6];
              next_link.bit_cnt = link.bit_cnt + 4'h1;
            end
          end
        end
        PH_TXACK:
        begin
          if (scl_rise)
            next_link.master_ack = !link.sda_f;
          else if (scl_fall)
          begin
            if (link.master_ack)
            begin
              next_link.shreg = tx_byte(link);
              next_link.sda_oe_n = next_link.shreg[7];
              next_link.half = !link.half;
              next_link.phase = PH_TX;
            end
            else
              next_link.phase = PH_IGN;
          end
        end
        PH_IDLE, PH_IGN:
          next_link.phase = link.phase;
        default:
          next_link.phase = PH_IDLE;
      endcase
    end
    if (!link.rst_sync)
    begin
      next_link = '0;
      next_link.rst_meta = rstn;
      next_link.rst_sync = link.rst_meta;
      // Whole pin pipelines start at the idle-high level, so no false edge follows reset
      {next_link.scl_meta, next_link.scl_sync, next_link.scl_d, next_link.scl_f, next_link.scl_p} = 5'h1F;
      {next_link.sda_meta, next_link.sda_sync, next_link.sda_d, next_link.sda_f, next_link.sda_p} = 5'h1F;
      next_link.phase = PH_IDLE;
      next_link.div = DIV_RESET;
      next_link.presc = PRESC_RESET;
      next_link.sel = SEL_RESET;
      next_link.mode = MODE_RESET;
      next_link.sda_oe_n = 1'b1;
    end
  end

  // Reset is applied through the combinational copy, so it stays synchronous
  always_ff @(posedge link_clk)
    link <= next_link;

  // ---------------------------------------------
  // Store side and outputs
  // ---------------------------------------------
  assign lnk.req = link.req;
  assign lnk.mask = link.mask;
  assign lnk.div = link.div;
  assign lnk.presc = link.presc;
  assign lnk.sel = link.sel;
  assign lnk.mode = link.mode;

  nv_commit_core #(
    .WRITE_CYCLES(NV_WRITE_CYCLES)
  ) u_core (
    .clk(clk),
    .rstn(rstn),
    .lnk(lnk),
    .nv_busy(nv_busy),
    .nv_write_strobe(nv_write_strobe),
    .nv_divider_word(nv_divider_word),
    .nv_prescaler_config_word(nv_prescaler_config_word),
    .nv_select_bits(nv_select_bits),
    .nv_commit_mode_stored(nv_commit_mode_stored)
  );

  // Only ever pulls low; the pad releases when the enable is high
  assign sda_out = 1'b0;
  assign sda_oe_n = link.sda_oe_n;
  assign divider_word = link.div;
  assign prescaler_config_word = link.presc;
  assign nv_commit_mode = link.mode;
  assign select_bit_2 = link.sel[2];
  assign select_bit_1 = link.sel[1];
  assign select_bit_0 = link.sel[0];

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking lcb @(posedge link_clk); endclocking
  default disable iff (!link.rst_sync);

  sequence ctrl_slot;
    link.phase == PH_ACK && link.byte_idx == 2'h1;
  endsequence
  sequence read_granted;
    ctrl_slot and (link.go_tx && scl_fall);
  endsequence
  sequence master_nack;
    link.phase == PH_TXACK && !link.master_ack && scl_fall;
  endsequence
  // The edge at which the control byte's answer is decided
  sequence ctrl_end;
    link.phase == PH_RX && link.byte_idx == 2'h0 && link.bit_cnt == BYTE_BITS && scl_fall;
  endsequence

  a_sda_low_phase: assert property (
    $changed(link.sda_oe_n) && !$past(start_evt || stop_evt) |-> !$past(link.scl_f))
  else $error("SDA changed while SCL high");

  a_busy_nack: assert property (
    ctrl_slot and link_busy |-> link.sda_oe_n)
  else $error("acknowledged while store busy");

  a_type_mismatch: assert property (
    ctrl_slot and (link.shreg[TYPE_MSB:TYPE_LSB] != DEVICE_TYPE) |-> link.sda_oe_n)
  else $error("acknowledged foreign type code");

  a_select_match: assert property (
    ctrl_end and ctrl_match |=> !link.sda_oe_n)
  else $error("matching control byte not acknowledged");

  a_write_ack: assert property (
    link.phase == PH_ACK && link.byte_idx == 2'h2 |-> !link.sda_oe_n)
  else $error("written byte not acknowledged");

  a_read_transmit: assert property (
    read_granted |=> link.phase == PH_TX ##0 link.sda_oe_n == link.shreg[7])
  else $error("read did not start transmitting");

  a_master_nack: assert property (
    master_nack |=> (link.phase == PH_IGN && link.sda_oe_n) [*2])
  else $error("SDA not released after master nack");

  a_auto_commit: assert property (
    stop_evt && link.dirty_words && !link.mode |=> $changed(link.req) && link.mask[MASK_WORDS])
  else $error("write not committed with mode clear");

  a_hold_commit: assert property (
    (start_evt || stop_evt) && link.mode && !link.commit_cmd && !link.dirty_sel |=> $stable(link.req))
  else $error("commit issued with mode set");

  a_cmd_commit: assert property (
    stop_evt && link.commit_cmd |=> $changed(link.req) && link.mask[MASK_WORDS])
  else $error("commit command did not store words");

  a_select_store: assert property (
    stop_evt && link.dirty_sel |=> $changed(link.req) && link.mask[MASK_SEL])
  else $error("select write not stored");

  a_start_abort: assert property (
    start_evt |=> link.phase == PH_RX && link.byte_idx == 2'h0 && $stable(link.div) && $stable(link.sel))
  else $error("start did not restart cleanly");

  a_stop_idle: assert property (
    stop_evt |=> link.phase == PH_IDLE && link.sda_oe_n)
  else $error("stop did not return to idle");
endmodule : two_wire_slave_nv_commit
`default_nettype wire

// >>> bus_master.sv
`default_nettype none
// Master model: SCL idles high, SDA released means pulled up
module bus_master
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Pins only move at rising edges of the core clock
  task automatic dly(input int n);
    repeat (n) @(posedge clk);
  endtask : dly
  // One bit: 1.4 us low, 1.1 us high, i.e. 400 kHz
  task automatic bit_slot(input logic d, output logic q);
    sda_drv <= d;
    dly(220);
    scl <= 1'b1;
    dly(110);
    q = sda;
    dly(110);
    scl <= 1'b0;
    dly(60);
  endtask : bit_slot
  // Also serves as repeated START, as SDA is released first
  // SCL stays low long enough for the slave to drop a pending acknowledge first
  task automatic start();
    sda_drv <= 1'b1;
    dly(220);
    scl <= 1'b1;
    dly(220);
    sda_drv <= 1'b0;
    dly(220);
    scl <= 1'b0;
    dly(60);
  endtask : start
  task automatic stop();
    sda_drv <= 1'b0;
    dly(220);
    scl <= 1'b1;
    dly(220);
    sda_drv <= 1'b1;
    dly(300);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) bit_slot(b[i], nack);
    bit_slot(1'b1, nack);
  endtask : wbyte
  // Last byte is left unacknowledged so the slave lets go
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(1'b1, q);
      b[i] = q;
    end
    bit_slot(last, q);
  endtask : rbyte
endmodule : bus_master
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench
  import two_wire_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short store time, still longer than one control byte
  localparam int NVW = 8000;
  localparam logic [7:0] WR = {DEVICE_TYPE_DEF, 4'h0};
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  wire logic scl, m_sda, sda, sda_out, sda_oe_n, mode, s2, s1, s0, busy, strobe, nmode;
  wire logic [9:0] dw, pw, ndw, npw;
  wire logic [2:0] nsel;
  int failures = 0;
  int checked = 0;
  int strobes = 0;
  // ----------------------------------------
  // Clocks, wire and instances
  // ----------------------------------------
  always #2.5 clk = ~clk;
  // Odd offset keeps the link clock out of step with the core clock
  initial
  begin
    #33.3;
    forever #80 link_clk = ~link_clk;
  end
  assign sda = m_sda & (sda_oe_n | sda_out);
  bus_master bus_master_i (.clk(clk), .sda(sda), .scl(scl), .sda_drv(m_sda));
  two_wire_slave_nv_commit #(.DEVICE_TYPE(DEVICE_TYPE_DEF), .NV_WRITE_CYCLES(NVW)) two_wire_slave_nv_commit_i
  (.clk(clk), .rstn(rstn), .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .divider_word(dw), .prescaler_config_word(pw), .nv_commit_mode(mode),
   .select_bit_2(s2), .select_bit_1(s1), .select_bit_0(s0), .nv_busy(busy), .nv_write_strobe(strobe),
   .nv_divider_word(ndw), .nv_prescaler_config_word(npw), .nv_select_bits(nsel),
   .nv_commit_mode_stored(nmode));
  // Counts store writes; sampled mid-cycle where the strobe is settled
  always @(negedge clk)
    if (strobe === 1'b1) strobes++;
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b, input logic nack);
    logic q;
    bus_master_i.wbyte(b, q);
    chk("ack", {9'h0, q}, {9'h0, nack});
  endtask : wr
  task automatic rd(input logic last, input logic [7:0] e);
    logic [7:0] b;
    bus_master_i.rbyte(last, b);
    chk("read", {2'h0, b}, {2'h0, e});
  endtask : rd
  // Bounded waits for a store to begin and then to finish
  task automatic store_wait(input logic e);
    int n;
    for (n = 0; n < 400 && busy !== 1'b1; n++) @(negedge clk);
    chk("store", {9'h0, busy}, {9'h0, e});
    for (n = 0; n < NVW + 40 && busy !== 1'b0; n++) @(negedge clk);
  endtask : store_wait
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (130) @(posedge clk);
    rstn <= 1'b1;
    repeat (140) @(posedge clk);
    chk("reset", {mode, s2, s1, s0, dw[5:0]}, 10'h000);
    bus_master_i.start();
    wr(WR, 1'b0);
    wr(CMD_DIV, 1'b0);
    wr(8'hFF, 1'b0);
    wr(8'hC0, 1'b0);
    bus_master_i.stop();
    chk("div", dw, 10'h3FF);
    bus_master_i.start();
    wr(WR, 1'b1);
    bus_master_i.stop();
    store_wait(1'b1);
    chk("nv div", ndw, 10'h3FF);
    $display("test auto store done");
    bus_master_i.start();
    wr(WR, 1'b0);
    wr(CMD_SELECT, 1'b0);
    wr(8'h08, 1'b0);
    bus_master_i.stop();
    store_wait(1'b1);
    chk("nv mode", {9'h0, nmode}, 10'h001);
    bus_master_i.start();
    wr(WR, 1'b0);
    wr(CMD_PRESC, 1'b0);
    wr(8'h55, 1'b0);
    wr(8'h40, 1'b0);
    bus_master_i.stop();
    chk("presc", pw, 10'h155);
    store_wait(1'b0);
    bus_master_i.start();
    wr(WR, 1'b0);
    wr(CMD_COMMIT, 1'b0);
    bus_master_i.stop();
    store_wait(1'b1);
    chk("nv presc", npw, 10'h155);
    $display("test commit done");
    bus_master_i.start();
    wr(WR, 1'b0);
    wr(CMD_DIV, 1'b0);
    bus_master_i.start();
    wr(WR | 8'h01, 1'b0);
    rd(1'b0, 8'hFF);
    rd(1'b1, 8'hC0);
    bus_master_i.stop();
    $display("test read done");
    bus_master_i.start();
    wr(WR, 1'b0);
    wr(CMD_SELECT, 1'b0);
    wr(8'h03, 1'b0);
    bus_master_i.stop();
    store_wait(1'b1);
    chk("nv sel", {7'h0, nsel}, 10'h003);
    chk("sel", {7'h0, s2, s1, s0}, 10'h003);
    bus_master_i.start();
    wr(WR, 1'b1);
    bus_master_i.start();
    wr(WR ^ 8'h86, 1'b1);
    bus_master_i.start();
    wr(WR | 8'h06, 1'b0);
    bus_master_i.stop();
    chk("strobes", 10'(strobes), 10'h004);
    $display("test select done");
    end_of_test();
  end
  // Run needs about 155k cycles
  initial
  begin
    repeat (200000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
